// file: design/hrrs_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module hrrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  assign empty       = (wr_ptr_reg == rd_ptr_reg);
  assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign do_push     = in_valid_i && !full;
  assign do_pop      = out_ready_i && !empty;

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// file: design/hrrs_pkg.sv
// Types shared by the holding register read slave.
package hrrs_pkg;
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_EVAL   = 8'h02,
    ST_HEAD   = 8'h04,
    ST_RDREQ  = 8'h08,
    ST_RDWAIT = 8'h10,
    ST_RDCAP  = 8'h20,
    ST_DATA   = 8'h40,
    ST_CRC    = 8'h80
  } hrrs_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic [15:0] start;
    logic [15:0] count;
  } hrrs_query_t;
endpackage

// file: design/hrrs_regs.svh
// Protocol constants for the holding register read slave.
`ifndef HRRS_REGS_SVH
`define HRRS_REGS_SVH
`define HRRS_FN_READ     8'h03
`define HRRS_FN_LOG      8'h40
`define HRRS_ERR_FLAG    8'h80
`define HRRS_BCAST_ADDR  8'h00
`define HRRS_EXC_FUNC    8'h01
`define HRRS_EXC_VALUE   8'h03
`define HRRS_QUERY_LEN   4'h8
`define HRRS_MIN_LEN     4'h4
`define HRRS_MAX_WORDS   8'h0A
`define HRRS_CRC_INIT    16'hFFFF
`define HRRS_CRC_POLY    16'hA001
`define HRRS_CRC_RESIDUE 16'h0000
`endif

// file: design/hrrs_slave.sv
// Message checker and read-holding-register responder of a serial slave.
`timescale 1ns/1ns
`include "hrrs_regs.svh"
module hrrs_slave #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  own_addr_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_end_i,
  output logic             reg_rd_o,
  output logic [15:0]      reg_addr_o,
  input  wire logic [15:0] reg_rdata_i,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  output logic             busy_o,
  output logic             frame_err_o
);
  hrrs_pkg::hrrs_state_t state_reg;
  hrrs_pkg::hrrs_state_t state_next;
  hrrs_pkg::hrrs_query_t q_reg;
  logic [3:0]  rx_len_reg;
  logic [15:0] rx_crc_reg;
  logic [15:0] tx_crc_reg;
  logic        resp_err_reg;
  logic [7:0]  resp_exc_reg;
  logic        is_log_reg;
  logic [7:0]  word_cnt_reg;
  logic [7:0]  word_idx_reg;
  logic [15:0] word_reg;
  logic [15:0] last_count_reg;
  logic [1:0]  step_reg;
  logic        reg_rd_reg;
  logic [15:0] reg_addr_reg;
  logic        tx_valid_reg;
  logic [7:0]  tx_data_reg;
  logic        busy_reg;
  logic        frame_err_reg;
  logic        crc_ok;
  logic        for_me;
  logic        count_ok;
  logic        pushing;
  logic        push_valid;
  logic [7:0]  push_data;
  logic        step_last;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_out_ready;

  // Reflected CRC step over one byte, least significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `HRRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Running the CRC over the trailing CRC bytes too leaves a zero residue.
  assign crc_ok = (rx_crc_reg == `HRRS_CRC_RESIDUE) && (rx_len_reg >= `HRRS_MIN_LEN);
  assign for_me   = (q_reg.addr == own_addr_i) && (q_reg.addr != `HRRS_BCAST_ADDR);
  assign count_ok = (rx_len_reg == `HRRS_QUERY_LEN) && (q_reg.count != 16'h0000) &&
                    (q_reg.count <= {8'h00, `HRRS_MAX_WORDS});

  assign push_valid = (state_reg == hrrs_pkg::ST_HEAD) || (state_reg == hrrs_pkg::ST_DATA) ||
                      (state_reg == hrrs_pkg::ST_CRC);
  assign pushing    = push_valid && fifo_in_ready;

  always_comb begin
    push_data = 8'h00;
    step_last = 1'b0;
    case (state_reg)
      hrrs_pkg::ST_HEAD: begin
        step_last = is_log_reg ? (step_reg == 2'd1) : (step_reg == 2'd2);
        if (step_reg == 2'd0) begin
          push_data = q_reg.addr;
        end else if (step_reg == 2'd1) begin
          push_data = resp_err_reg ? (q_reg.func | `HRRS_ERR_FLAG) : q_reg.func;
        end else begin
          push_data = resp_err_reg ? resp_exc_reg : {word_cnt_reg[6:0], 1'b0};
        end
      end
      hrrs_pkg::ST_DATA: begin
        step_last = (step_reg == 2'd1);
        push_data = (step_reg == 2'd0) ? word_reg[15:8] : word_reg[7:0];
      end
      hrrs_pkg::ST_CRC: begin
        step_last = (step_reg == 2'd1);
        push_data = (step_reg == 2'd0) ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
      end
      default: begin
        push_data = 8'h00;
        step_last = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hrrs_pkg::ST_IDLE: begin
        if (rx_end_i) begin
          state_next = hrrs_pkg::ST_EVAL;
        end
      end
      hrrs_pkg::ST_EVAL: begin
        // Broadcasts are never answered, which covers functions 03 and 40.
        state_next = (crc_ok && for_me) ? hrrs_pkg::ST_HEAD : hrrs_pkg::ST_IDLE;
      end
      hrrs_pkg::ST_HEAD: begin
        if (pushing && step_last) begin
          state_next = resp_err_reg ? hrrs_pkg::ST_CRC :
                       is_log_reg ? hrrs_pkg::ST_DATA : hrrs_pkg::ST_RDREQ;
        end
      end
      hrrs_pkg::ST_RDREQ:  state_next = hrrs_pkg::ST_RDWAIT;
      hrrs_pkg::ST_RDWAIT: state_next = hrrs_pkg::ST_RDCAP;
      hrrs_pkg::ST_RDCAP:  state_next = hrrs_pkg::ST_DATA;
      hrrs_pkg::ST_DATA: begin
        if (pushing && step_last) begin
          state_next = (!is_log_reg && (word_idx_reg + 8'h01 < word_cnt_reg)) ?
                       hrrs_pkg::ST_RDREQ : hrrs_pkg::ST_CRC;
        end
      end
      hrrs_pkg::ST_CRC: begin
        if (pushing && step_last) begin
          state_next = hrrs_pkg::ST_IDLE;
        end
      end
      default: state_next = hrrs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= hrrs_pkg::ST_IDLE;
      step_reg  <= 2'd0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        step_reg <= 2'd0;
      end else if (pushing) begin
        step_reg <= step_reg + 2'd1;
      end
    end
  end

  // Receive side: bytes arriving while a reply is being built are dropped.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg      <= '0;
      rx_len_reg <= 4'h0;
      rx_crc_reg <= `HRRS_CRC_INIT;
    end else if (state_reg == hrrs_pkg::ST_EVAL) begin
      rx_len_reg <= 4'h0;
      rx_crc_reg <= `HRRS_CRC_INIT;
    end else if ((state_reg == hrrs_pkg::ST_IDLE) && rx_valid_i && !rx_end_i) begin
      rx_crc_reg <= crc_byte(rx_crc_reg, rx_data_i);
      if (rx_len_reg != 4'hF) begin
        rx_len_reg <= rx_len_reg + 4'h1;
      end
      case (rx_len_reg)
        4'h0: q_reg.addr         <= rx_data_i;
        4'h1: q_reg.func         <= rx_data_i;
        4'h2: q_reg.start[15:8]  <= rx_data_i;
        4'h3: q_reg.start[7:0]   <= rx_data_i;
        4'h4: q_reg.count[15:8]  <= rx_data_i;
        4'h5: q_reg.count[7:0]   <= rx_data_i;
        default: q_reg.addr      <= q_reg.addr;
      endcase
    end
  end

  // Decision on the checked query and the access log it leaves behind.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_err_reg   <= 1'b0;
      resp_exc_reg   <= 8'h00;
      is_log_reg     <= 1'b0;
      word_cnt_reg   <= 8'h00;
      last_count_reg <= 16'h0000;
    end else if ((state_reg == hrrs_pkg::ST_EVAL) && crc_ok && for_me) begin
      is_log_reg   <= (q_reg.func == `HRRS_FN_LOG);
      resp_err_reg <= 1'b0;
      if (q_reg.func == `HRRS_FN_READ) begin
        if (count_ok) begin
          word_cnt_reg   <= q_reg.count[7:0];
          last_count_reg <= q_reg.count;
        end else begin
          resp_err_reg   <= 1'b1;
          resp_exc_reg   <= `HRRS_EXC_VALUE;
          last_count_reg <= 16'h0000;
        end
      end else if (q_reg.func != `HRRS_FN_LOG) begin
        resp_err_reg   <= 1'b1;
        resp_exc_reg   <= `HRRS_EXC_FUNC;
        last_count_reg <= 16'h0000;
      end
    end
  end

  // Register fetch, one word at a time, ascending from the query start address.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_idx_reg <= 8'h00;
      word_reg     <= 16'h0000;
      reg_rd_reg   <= 1'b0;
      reg_addr_reg <= 16'h0000;
    end else begin
      reg_rd_reg <= (state_reg == hrrs_pkg::ST_RDREQ);
      if (state_reg == hrrs_pkg::ST_EVAL) begin
        word_idx_reg <= 8'h00;
        word_reg     <= last_count_reg;
      end
      if (state_reg == hrrs_pkg::ST_RDREQ) begin
        reg_addr_reg <= q_reg.start + {8'h00, word_idx_reg};
      end
      if (state_reg == hrrs_pkg::ST_RDCAP) begin
        word_reg <= reg_rdata_i;
      end
      if ((state_reg == hrrs_pkg::ST_DATA) && pushing && step_last) begin
        word_idx_reg <= word_idx_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_crc_reg <= `HRRS_CRC_INIT;
    end else if (state_reg == hrrs_pkg::ST_EVAL) begin
      tx_crc_reg <= `HRRS_CRC_INIT;
    end else if (pushing && (state_reg != hrrs_pkg::ST_CRC)) begin
      tx_crc_reg <= crc_byte(tx_crc_reg, push_data);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg      <= 1'b0;
      frame_err_reg <= 1'b0;
    end else begin
      busy_reg      <= (state_next != hrrs_pkg::ST_IDLE);
      frame_err_reg <= (state_reg == hrrs_pkg::ST_EVAL) && !crc_ok;
    end
  end

  hrrs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // Output stage keeps every transmit pin on a flip-flop.
  assign fifo_out_ready = !tx_valid_reg || tx_ready_i;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
    end else if (fifo_out_ready) begin
      tx_valid_reg <= fifo_out_valid;
      if (fifo_out_valid) begin
        tx_data_reg <= fifo_out_data;
      end
    end
  end

  assign reg_rd_o    = reg_rd_reg;
  assign reg_addr_o  = reg_addr_reg;
  assign tx_valid_o  = tx_valid_reg;
  assign tx_data_o   = tx_data_reg;
  assign busy_o      = busy_reg;
  assign frame_err_o = frame_err_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_eval_good;
    (state_reg == hrrs_pkg::ST_EVAL) && crc_ok && for_me;
  endsequence
  sequence s_fetch;
    (state_reg == hrrs_pkg::ST_RDREQ) ##1 reg_rd_o ##1 (state_reg == hrrs_pkg::ST_RDCAP);
  endsequence

  a_crc_reject: assert property ((state_reg == hrrs_pkg::ST_EVAL) && !crc_ok
    |=> (state_reg == hrrs_pkg::ST_IDLE) && frame_err_o)
    else $error("bad CRC frame was not dropped");
  a_bcast_silent: assert property ((state_reg == hrrs_pkg::ST_EVAL) &&
    (q_reg.addr == `HRRS_BCAST_ADDR) |=> (state_reg == hrrs_pkg::ST_IDLE))
    else $error("broadcast query was answered");
  a_err_function: assert property ((state_reg == hrrs_pkg::ST_HEAD) && pushing &&
    resp_err_reg && (step_reg == 2'd1) |-> (push_data == (q_reg.func | `HRRS_ERR_FLAG)))
    else $error("error reply lacks flagged function code");
  a_unsup_error: assert property (s_eval_good and ((q_reg.func != `HRRS_FN_READ) &&
    (q_reg.func != `HRRS_FN_LOG)) |=> resp_err_reg && (resp_exc_reg == `HRRS_EXC_FUNC))
    else $error("unsupported function not rejected");
  a_byte_count: assert property ((state_reg == hrrs_pkg::ST_HEAD) && pushing &&
    !resp_err_reg && !is_log_reg && (step_reg == 2'd2) |->
    (push_data == {q_reg.count[6:0], 1'b0}) && (push_data >= 8'h02) && (push_data <= 8'h14))
    else $error("byte count wrong or out of range");
  a_word_order: assert property (s_fetch |->
    (reg_addr_o == q_reg.start + {8'h00, word_idx_reg}) ##1 (word_reg == $past(reg_rdata_i)))
    else $error("register fetch out of order");
  a_data_hi_first: assert property ((state_reg == hrrs_pkg::ST_DATA) && pushing &&
    (step_reg == 2'd0) |-> (push_data == word_reg[15:8]))
    else $error("register word not sent high byte first");
  a_crc_lo_first: assert property ((state_reg == hrrs_pkg::ST_CRC) && pushing &&
    (step_reg == 2'd0) |-> (push_data == tx_crc_reg[7:0]) ##[1:300]
    ((state_reg == hrrs_pkg::ST_IDLE) && $past(push_data) == tx_crc_reg[15:8]))
    else $error("CRC bytes not sent low then high");
  a_log_count: assert property (s_eval_good and (q_reg.func == `HRRS_FN_LOG) |=>
    is_log_reg && (word_reg == $past(last_count_reg)))
    else $error("access log reply does not carry last count");
endmodule

// file: tb/hrrs_master_model.sv
// Behavioural serial bus master that sends query frames and takes reply bytes.
`timescale 1ns/1ns
module hrrs_master_model (
  input  wire logic       clock_i,
  input  wire logic       slow_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_end_o,
  output logic            tx_ready_o
);
  logic [1:0] stall_cnt;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_end_o   = 1'b0;
    tx_ready_o = 1'b1;
    stall_cnt  = 2'h0;
  end

  // A slow master takes one byte in four, so the reply buffer fills and the slave must stall.
  always @(posedge clock_i) begin
    stall_cnt  <= stall_cnt + 2'h1;
    tx_ready_o <= !slow_i || stall_cnt == 2'h0;
  end

  // Bytes leave in the order given, the check pair low byte first.
  task automatic send_frame(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge clock_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= q[i];
    end
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    // The data line carries no byte now, so it must not look like the last one.
    rx_data_o  <= ~rx_data_o;
    rx_end_o   <= 1'b1;
    @(posedge clock_i);
    rx_end_o   <= 1'b0;
  endtask
endmodule

// file: tb/hrrs_slave_tb.sv
// Self-checking bench for the holding register read slave.
`timescale 1ns/1ns
module hrrs_slave_tb;
  logic        clock_i;
  logic        rst_n_i;
  logic [7:0]  own_addr_i;
  logic        rx_valid_i;
  logic [7:0]  rx_data_i;
  logic        rx_end_i;
  logic        reg_rd_o;
  logic [15:0] reg_addr_o;
  logic [15:0] reg_rdata_i;
  logic        tx_valid_o;
  logic [7:0]  tx_data_o;
  logic        tx_ready_i;
  logic        busy_o;
  logic        frame_err_o;
  logic        slow;
  int          num_errors = 0;
  int          checked = 0;
  int          ferr_cnt = 0;
  logic [15:0] log_n = 16'h0000;
  logic [31:0] seed = 32'h0000_0031;
  logic [7:0]  exp_q[$];
  logic [15:0] exp_a[$];
  logic [15:0] cnt_tab [6] = '{16'h0001, 16'h000A, 16'h0002, 16'h0000, 16'h000B, 16'h0007};
  logic [7:0]  bad_tab [5] = '{8'h01, 8'h06, 8'h08, 8'h10, 8'hFF};

  hrrs_slave u_hrrs_slave (.clock_i(clock_i), .rst_n_i(rst_n_i), .own_addr_i(own_addr_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_end_i(rx_end_i), .reg_rd_o(reg_rd_o),
    .reg_addr_o(reg_addr_o), .reg_rdata_i(reg_rdata_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .busy_o(busy_o), .frame_err_o(frame_err_o));
  hrrs_master_model u_hrrs_master_model (.clock_i(clock_i), .slow_i(slow),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_end_o(rx_end_i), .tx_ready_o(tx_ready_i));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction

  // Register contents are a fixed scramble of the address, so a wrong address shows as bad data.
  function automatic logic [15:0] rdval(input logic [15:0] a);
    return {a[7:0], ~a[15:8]} ^ 16'h5A3C;
  endfunction

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) reg_rdata_i <= (reg_rd_o === 1'b1) ? rdval(reg_addr_o) : ~reg_rdata_i;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge clock_i) begin
    if (frame_err_o === 1'b1) ferr_cnt++;
    // Every register fetch must hit the next address that the query asked for.
    if (reg_rd_o === 1'b1) begin
      if (exp_a.size() == 0) chk16(reg_addr_o, ~reg_addr_o);
      else chk16(reg_addr_o, exp_a.pop_front());
    end
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) chk8(tx_data_o, ~tx_data_o);
      else chk8(tx_data_o, exp_q.pop_front());
    end
  end

  task automatic expect_reply(input logic [7:0] r[$]);
    logic [15:0] c;
    c = crc(r);
    foreach (r[i]) exp_q.push_back(r[i]);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
  endtask

  task automatic send(input logic [7:0] q[$], input logic addcrc, input int ferr);
    logic [15:0] c;
    int          f0;
    int          n;
    c = crc(q);
    f0 = ferr_cnt;
    n = 0;
    if (addcrc) begin
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
    end
    u_hrrs_master_model.send_frame(q);
    @(posedge clock_i);
    // The end-of-frame edge has just been taken, so evaluation must show as busy.
    chk8({7'h00, busy_o}, 8'h01);
    repeat (3) @(posedge clock_i);
    while ((busy_o !== 1'b0 || exp_q.size() != 0) && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    chk8(8'(n >= 3000), 8'h00);
    repeat (3) @(posedge clock_i);
    chk16(16'(ferr_cnt - f0), 16'(ferr));
    chk16(16'(exp_q.size()), 16'h0000);
    chk16(16'(exp_a.size()), 16'h0000);
    exp_q.delete();
    exp_a.delete();
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] st, input logic [15:0] n);
    logic [7:0]  r[$];
    logic [15:0] w;
    if (a == own_addr_i && n >= 16'h0001 && n <= 16'h000A) begin
      r = {a, 8'h03, 8'(2 * n)};
      for (int i = 0; i < n; i++) begin
        w = rdval(st + 16'(i));
        exp_a.push_back(st + 16'(i));
        r.push_back(w[15:8]);
        r.push_back(w[7:0]);
      end
      log_n = n;
      expect_reply(r);
    end else if (a == own_addr_i) begin
      log_n = 16'h0000;
      expect_reply({a, 8'h83, 8'h03});
    end
    send({a, 8'h03, st[15:8], st[7:0], n[15:8], n[7:0]}, 1'b1, 0);
  endtask

  task automatic fn40(input logic [7:0] a);
    if (a == own_addr_i) expect_reply({a, 8'h40, log_n[15:8], log_n[7:0]});
    send({a, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b1, 0);
  endtask

  task automatic close_out();
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock_i);
    num_errors++;
    close_out();
  end

  initial begin
    logic [7:0]  q[$];
    logic [15:0] c;
    rst_n_i = 1'b0;
    own_addr_i = 8'h11;
    reg_rdata_i = 16'h0000;
    slow = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    q = {8'h11, 8'h03, 8'h03, 8'hEB, 8'h00, 8'h03};
    chk16(crc(q), 16'h2B77);
    rd(8'h11, 16'h03EB, 16'h0003);
    fn40(8'h11);
    for (int k = 0; k < 6; k++) begin
      slow <= k[0];
      rd(8'h11, 16'(xs()) & 16'h7FFF, cnt_tab[k]);
      fn40(8'h11);
    end
    rd(8'h11, 16'h0010, 16'h0004);
    foreach (bad_tab[k]) begin
      log_n = 16'h0000;
      expect_reply({8'h11, bad_tab[k] | 8'h80, 8'h01});
      send({8'h11, bad_tab[k], 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1, 0);
    end
    fn40(8'h11);
    rd(8'h11, 16'h0020, 16'h0005);
    rd(8'h00, 16'h0020, 16'h0002);
    fn40(8'h00);
    rd(8'h12, 16'h0020, 16'h0002);
    fn40(8'h11);
    q = {8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    c = crc(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8] ^ 8'h01);
    send(q, 1'b0, 1);
    send({8'h11, 8'h03}, 1'b0, 1);
    log_n = 16'h0000;
    expect_reply({8'h11, 8'h83, 8'h03});
    send({8'h11, 8'h03, 8'h00, 8'h00, 8'h01}, 1'b1, 0);
    own_addr_i <= 8'hF7;
    @(posedge clock_i);
    slow <= 1'b1;
    rd(8'hF7, 16'(xs()) & 16'h7FFF, 16'h000A);
    fn40(8'hF7);
    close_out();
  end
endmodule
